// *** design/ddl_pkg.sv ***
// Package with constants for the dual converter serial load logic
`default_nettype none
package ddl_pkg;
  localparam int          WORD_W        = 16;
  localparam int          DATA_W        = 12;
  localparam int          DATA_LSB      = 0;
  localparam int          SEL_FIRST_POS = 13;
  localparam int          SEL_SECOND_POS= 14;
  localparam int          MODE_POS      = 15;
  localparam logic [11:0] CODE_ZERO     = 12'h000;
  localparam logic [11:0] CODE_MID      = 12'h800;
  localparam logic [11:0] CODE_FULL     = 12'hFFF;
  localparam int          SYNC_STAGES   = 2;
  // Register map
  localparam logic [11:0] ADDR_WORD     = 12'h000;
  localparam logic [11:0] ADDR_CONV_A   = 12'h004;
  localparam logic [11:0] ADDR_CONV_B   = 12'h008;
  localparam logic [11:0] ADDR_STATUS   = 12'h00C;
  localparam logic [11:0] ADDR_CTRL     = 12'h010;
  localparam int          CTRL_PRESET_LVL = 0;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
endpackage : ddl_pkg
`default_nettype wire

// *** design/ddl_sync.sv ***
// Two flip-flop synchroniser for a group of pin inputs
`default_nettype none
module ddl_sync #(
  parameter int          WIDTH    = 1,
  parameter logic [31:0] INIT_VAL = 32'h0000_0000
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= INIT_VAL[WIDTH-1:0];
      sync_out <= INIT_VAL[WIDTH-1:0];
    end else begin
      meta_reg <= meta_next;
      sync_out <= sync_next;
    end
  end
endmodule : ddl_sync
`default_nettype wire

// *** design/ddl_top.sv ***
// Serial load logic of a dual 12-bit converter with APB register access
//
// The address map and the APB register port were left to the implementer.
`default_nettype none
module ddl_top #(
  parameter int WORD_W = ddl_pkg::WORD_W,
  parameter int DATA_W = ddl_pkg::DATA_W
) (
  // System clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Serial link pins
  input  wire logic        serial_clk,
  input  wire logic        serial_in,
  input  wire logic        chip_select_n,
  output logic             serial_out,
  // Load and preset pins
  input  wire logic        load_strobe_a_n,
  input  wire logic        load_strobe_b_n,
  input  wire logic        async_preset_n,
  input  wire logic        preset_level_select,
  // Converter codes
  output logic [DATA_W-1:0] conv_a_code,
  output logic [DATA_W-1:0] conv_b_code,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  // Pin synchronisers: clock, data, select, strobe A, strobe B, preset, level
  logic [6:0] pin_raw;
  logic [6:0] pin_s;
  assign pin_raw = {preset_level_select, async_preset_n, load_strobe_b_n,
                    load_strobe_a_n, chip_select_n, serial_in, serial_clk};

  ddl_sync #(
    .WIDTH    (7),
    .INIT_VAL (32'h0000_003C)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .async_in (pin_raw),
    .sync_out (pin_s)
  );

  logic s_clk;
  logic s_data;
  logic s_cs_n;
  logic s_lda_n;
  logic s_ldb_n;
  logic s_rs_n;
  logic s_lvl;
  assign s_clk   = pin_s[0];
  assign s_data  = pin_s[1];
  assign s_cs_n  = pin_s[2];
  assign s_lda_n = pin_s[3];
  assign s_ldb_n = pin_s[4];
  assign s_rs_n  = pin_s[5];
  assign s_lvl   = pin_s[6];

  // Edge history
  logic clk_d_reg;
  logic clk_d_next;
  logic lda_d_reg;
  logic lda_d_next;
  logic ldb_d_reg;
  logic ldb_d_next;

  // Shift register and converter registers
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] shift_next;
  logic              sout_reg;
  logic              sout_next;
  logic [DATA_W-1:0] conv_a_reg;
  logic [DATA_W-1:0] conv_b_reg;
  logic [1:0]        ch_load;
  logic [7:0]        load_cnt_reg;
  logic [7:0]        load_cnt_next;

  // Control register
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;

  // APB outputs
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;

  logic clk_rise;
  logic fall_a;
  logic fall_b;
  logic mode_sw;
  logic sel_first;
  logic sel_second;
  logic load_a;
  logic load_b;
  logic preset_now;
  logic preset_mid;
  logic [DATA_W-1:0] preset_code;
  logic [DATA_W-1:0] word_data;

  // Strobe edges, word fields and load decode
  always_comb begin
    clk_rise   = s_clk && !clk_d_reg;
    fall_a     = lda_d_reg && !s_lda_n;
    fall_b     = ldb_d_reg && !s_ldb_n;
    mode_sw    = shift_reg[ddl_pkg::MODE_POS];
    sel_first  = shift_reg[ddl_pkg::SEL_FIRST_POS];
    sel_second = shift_reg[ddl_pkg::SEL_SECOND_POS];
    word_data  = shift_reg[ddl_pkg::DATA_LSB +: DATA_W];
    preset_now = !s_rs_n;
    preset_mid = s_lvl || ctrl_reg[ddl_pkg::CTRL_PRESET_LVL];
    preset_code = preset_mid ? ddl_pkg::CODE_MID : ddl_pkg::CODE_ZERO;
    if (mode_sw) begin
      load_a = (fall_a || fall_b) && sel_first;
      load_b = (fall_a || fall_b) && sel_second;
    end else begin
      load_a = fall_a;
      load_b = fall_b;
    end
  end

  // Edge history of link clock and strobes
  always_comb begin
    clk_d_next = s_clk;
    lda_d_next = s_lda_n;
    ldb_d_next = s_ldb_n;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      clk_d_reg <= 1'b0;
      lda_d_reg <= 1'b1;
      ldb_d_reg <= 1'b1;
    end else begin
      clk_d_reg <= clk_d_next;
      lda_d_reg <= lda_d_next;
      ldb_d_reg <= ldb_d_next;
    end
  end

  // Input shift register and serial output
  always_comb begin
    shift_next = shift_reg;
    sout_next  = sout_reg;
    if (clk_rise && !s_cs_n) begin
      shift_next = {shift_reg[WORD_W-2:0], s_data};
      sout_next  = shift_reg[WORD_W-1];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shift_reg <= '0;
      sout_reg  <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      sout_reg  <= sout_next;
    end
  end

  // Converter code registers, one per channel; preset wins over loads
  assign ch_load = {load_b, load_a};

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [DATA_W-1:0] code_reg;
    logic [DATA_W-1:0] code_next;

    // Next code
    always_comb begin
      code_next = code_reg;
      if (preset_now) begin
        code_next = preset_code;
      end else if (ch_load[ch]) begin
        code_next = word_data;
      end
    end

    // Code register
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        code_reg <= ddl_pkg::CODE_ZERO;
      end else begin
        code_reg <= code_next;
      end
    end
  end

  assign conv_a_reg = g_chan[0].code_reg;
  assign conv_b_reg = g_chan[1].code_reg;

  // Count of load events, wraps
  always_comb begin
    load_cnt_next = load_cnt_reg;
    if (!preset_now && (load_a || load_b)) begin
      load_cnt_next = load_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      load_cnt_reg <= 8'h00;
    end else begin
      load_cnt_reg <= load_cnt_next;
    end
  end

  // APB slave, one wait state on every access
  logic access;
  assign access = psel && penable && !pready_reg;

  // Control register, written at the edge that completes the transfer
  logic commit;
  assign commit = psel && penable && pready_reg && pwrite;

  always_comb begin
    ctrl_next = ctrl_reg;
    if (commit && (paddr == ddl_pkg::ADDR_CTRL)) begin
      ctrl_next = {31'h0000_0000, pwdata[ddl_pkg::CTRL_PRESET_LVL]};
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= ddl_pkg::CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Response: ready, read data and error
  always_comb begin
    prdata_next  = prdata_reg;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    if (access) begin
      pready_next = 1'b1;
      prdata_next = 32'h0000_0000;
      unique case (paddr)
        ddl_pkg::ADDR_WORD: begin
          prdata_next = {16'h0000, shift_reg};
        end
        ddl_pkg::ADDR_CONV_A: begin
          prdata_next = {20'h0_0000, conv_a_reg};
        end
        ddl_pkg::ADDR_CONV_B: begin
          prdata_next = {20'h0_0000, conv_b_reg};
        end
        ddl_pkg::ADDR_STATUS: begin
          prdata_next = {16'h0000, load_cnt_reg, 4'h0, s_lvl, s_rs_n,
                         s_cs_n, mode_sw};
        end
        ddl_pkg::ADDR_CTRL: begin
          prdata_next = ctrl_reg;
        end
        default: begin
          pslverr_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign serial_out  = sout_reg;
  assign conv_a_code = conv_a_reg;
  assign conv_b_code = conv_b_reg;
  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
endmodule : ddl_top
`default_nettype wire

// *** verification/ddl_asserts.sv ***
// Checker for load, preset, shift and APB port behaviour
`default_nettype none
module ddl_asserts (
  // Clock, reset and pins
  input wire logic        clk_sys, rstn, chip_select_n, serial_out,
  input wire logic        load_strobe_a_n, load_strobe_b_n, async_preset_n, preset_level_select,
  // Codes and APB
  input wire logic [11:0] conv_a_code, conv_b_code, paddr,
  input wire logic        psel, penable, pready, pslverr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire logic idle = load_strobe_a_n & load_strobe_b_n & async_preset_n;
  wire logic acc  = psel & penable & !pready;
  property p_hold; idle [*5] |=> $stable(conv_a_code) && $stable(conv_b_code); endproperty
  a_hold: assert property (p_hold) else $error("code moved without load");
  property p_zero;
    (!async_preset_n && !preset_level_select) [*5] |->
      conv_a_code == 12'h000 && conv_b_code == 12'h000;
  endproperty
  a_zero: assert property (p_zero) else $error("preset did not clear");
  property p_mid;
    (!async_preset_n && preset_level_select) [*5] |->
      conv_a_code == 12'h800 && conv_b_code == 12'h800;
  endproperty
  a_mid: assert property (p_mid) else $error("preset did not give midscale");
  property p_cs; chip_select_n [*5] |=> $stable(serial_out); endproperty
  a_cs: assert property (p_cs) else $error("shift while deselected");
  property p_rdy; acc |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_bad; acc && paddr > 12'h010 |=> pslverr; endproperty
  a_bad: assert property (p_bad) else $error("unmapped not refused");
endmodule : ddl_asserts
bind ddl_top ddl_asserts u_chk (.clk_sys, .rstn, .chip_select_n, .serial_out, .load_strobe_a_n,
  .load_strobe_b_n, .async_preset_n, .preset_level_select, .conv_a_code, .conv_b_code, .paddr,
  .psel, .penable, .pready, .pslverr);
`default_nettype wire

// *** verification/ddl_host.sv ***
// Host serial port model driving link clock, data, select and strobes
`default_nettype none
module ddl_host (
  input  wire logic clk_sys,
  output logic      serial_clk, serial_in, chip_select_n, load_strobe_a_n, load_strobe_b_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {serial_clk, serial_in, chip_select_n, load_strobe_a_n, load_strobe_b_n} = 5'b00111;
  end
  // Word MSB first, 320 ns link clock, strobes high throughout
  task automatic send(input logic [15:0] w, input logic cs_n);
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk_sys);
      chip_select_n <= cs_n;
      serial_in     <= w[i];
      serial_clk    <= 1'b0;
      repeat (4) @(posedge clk_sys);
      serial_clk    <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    serial_clk <= 1'b0;
    serial_in  <= ~w[0];
    repeat (4) @(posedge clk_sys);
    chip_select_n <= 1'b1;
  endtask : send
  task automatic strobe(input logic a, input logic b);
    @(posedge clk_sys);
    load_strobe_a_n <= !a;
    load_strobe_b_n <= !b;
    repeat (4) @(posedge clk_sys);
    {load_strobe_a_n, load_strobe_b_n} <= 2'b11;
    repeat (6) @(posedge clk_sys);
  endtask : strobe
endmodule : ddl_host
`default_nettype wire

// *** verification/ddl_top_bench.sv ***
// Self-checking bench of the dual converter serial load logic
`default_nettype none
module ddl_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 0, rstn = 0, async_preset_n = 1, preset_level_select = 0;
  logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic        serial_clk, serial_in, chip_select_n, serial_out, load_strobe_a_n, load_strobe_b_n;
  logic [11:0] paddr = 12'h000, conv_a_code, conv_b_code;
  logic [31:0] pwdata = 32'h0, prdata;
  int          err_count = 0, n_tests = 0;
  logic        prev_b0 = 1'b0;
  // Word, strobes A B, expected A, expected B
  localparam logic [41:0] ROWS [7] = '{
    {16'h0123, 2'b10, 12'h123, 12'h000}, {16'h0456, 2'b01, 12'h123, 12'h456},
    {16'h0FFF, 2'b11, 12'hFFF, 12'hFFF}, {16'hA800, 2'b10, 12'h800, 12'hFFF},
    {16'hC7FF, 2'b01, 12'h800, 12'h7FF}, {16'hE001, 2'b10, 12'h001, 12'h001},
    {16'h8555, 2'b11, 12'h001, 12'h001}};
  always #20 clk_sys = ~clk_sys;
  ddl_host u_host (.clk_sys, .serial_clk, .serial_in, .chip_select_n, .load_strobe_a_n,
    .load_strobe_b_n);
  ddl_top DUT (.clk_sys, .rstn, .serial_clk, .serial_in, .chip_select_n, .serial_out,
    .load_strobe_a_n, .load_strobe_b_n, .async_preset_n, .preset_level_select, .conv_a_code,
    .conv_b_code, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, exp, input logic e);
    int k;
    @(posedge clk_sys);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) begin
      err_count++;
      test_done();
    end
    if (!w && !e) chk(prdata, exp);
    chk({31'h0, pslverr}, {31'h0, e});
    {psel, penable} <= 2'b00;
  endtask : apb
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    chk({conv_a_code, conv_b_code}, 24'h0);
    foreach (ROWS[i]) begin
      u_host.send(ROWS[i][41:26], 1'b0);
      chk(serial_out, prev_b0);
      prev_b0 = ROWS[i][26];
      u_host.strobe(ROWS[i][25], ROWS[i][24]);
      chk({conv_a_code, conv_b_code}, ROWS[i][23:0]);
      $display("Row %0d done", i);
    end
    // Deselected clocks ignored, strobe still loads
    u_host.send(16'h0ABC, 1'b0);
    u_host.send(16'h1234, 1'b1);
    apb(1'b0, 12'h000, 32'h0, 32'h0000_0ABC, 1'b0);
    u_host.strobe(1'b1, 1'b0);
    chk(conv_a_code, 12'hABC);
    apb(1'b0, 12'h004, 32'h0, 32'h0000_0ABC, 1'b0);
    apb(1'b0, 12'h00C, 32'h0, 32'h0000_0706, 1'b0);
    apb(1'b1, 12'h008, 32'h5, 32'h0, 1'b0);
    apb(1'b0, 12'h008, 32'h0, 32'h0000_0001, 1'b0);
    apb(1'b1, 12'h010, 32'h1, 32'h0, 1'b0);
    apb(1'b0, 12'h010, 32'h0, 32'h0000_0001, 1'b0);
    apb(1'b1, 12'h010, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 12'h014, 32'h0, 32'h0, 1'b1);
    $display("Select and bus test done");
    async_preset_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk({conv_a_code, conv_b_code}, 24'h000000);
    preset_level_select <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk({conv_a_code, conv_b_code}, 24'h800800);
    {async_preset_n, preset_level_select} <= 2'b10;
    repeat (6) @(posedge clk_sys);
    chk({conv_a_code, conv_b_code}, 24'h800800);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({conv_a_code, conv_b_code}, 24'h0);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk({conv_a_code, conv_b_code, 7'h00, serial_out}, 32'h0);
    $display("Preset and reset test done");
    test_done();
  end
endmodule : ddl_top_bench
`default_nettype wire
